// file: sdl_pkg.sv
// shared constants, types and ring helpers for the status/data logger
// assumes a single 125 MHz clock domain and synchronous active-low reset
package sdl_pkg;

    // connections that keep their own filter and held status
    localparam int NUM_CONN = 2;
    localparam int CONN_W   = 1;

    // status group 1 bit positions
    localparam int G1_ADC_DONE = 0;
    localparam int G1_PRINT_TMO = 2;
    localparam int G1_TIMED_LOGGING_TMO = 3;
    // status group 2 bit positions
    localparam int G2_MEAS_DROP = 0;
    localparam int G2_UNIT_CHG = 1;
    localparam int G2_CMD_ERR = 2;
    localparam int G2_EXEC_ERR = 3;
    // status group 3 bit positions
    localparam int G3_CHART_END = 1;
    localparam int G3_CHART_FEED = 5;
    // status group 4 bit positions
    localparam int G4_BASIC = 0;
    localparam int G4_REC = 1;
    localparam int G4_COMP = 2;
    localparam int G4_ALARM = 3;

    // implemented bits of each group, and the filter reset value
    localparam logic [7:0] G1_USED = 8'h0D;
    localparam logic [7:0] G2_USED = 8'h0F;
    localparam logic [7:0] G3_USED = 8'h22;
    localparam logic [7:0] G4_USED = 8'h0F;
    localparam logic [7:0] FILTER_RST = 8'hFF;

    // data ring sizes
    localparam int IDX_W = 8;
    localparam logic [IDX_W-1:0] PEN_DEPTH = 8'hF0;
    localparam logic [IDX_W-1:0] DOT_DEPTH = 8'h3C;
    localparam int MEM_WORDS = 240;
    localparam int DATA_W = 16;
    localparam int OUT_FIFO_DEPTH = 4;

    // per-block flag positions
    localparam int FLG_DROP = 0;
    localparam int FLG_IVL = 1;
    localparam int FLG_UNIT = 2;

    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam logic [15:0] IVL_RST_MS = 16'h03E8;

    // unit character codes
    localparam logic [7:0] CODE_MICRO = 8'h7B;
    localparam logic [7:0] CODE_OHM = 8'h7C;
    localparam logic [7:0] CODE_SQUARE = 8'h7D;
    localparam logic [7:0] CODE_CUBE = 8'h7E;
    localparam logic [7:0] CODE_DEGREE = 8'h5E;

    typedef enum logic [2:0] {
        UNIT_MICRO  = 3'h0,
        UNIT_OHM    = 3'h1,
        UNIT_SQUARE = 3'h2,
        UNIT_CUBE   = 3'h3,
        UNIT_DEGREE = 3'h4
    } sdl_unit_e;

    typedef enum logic [1:0] {
        RD_IDLE  = 2'b00,
        RD_FETCH = 2'b01,
        RD_PUSH  = 2'b10
    } sdl_rd_e;

    typedef struct packed {
        logic [2:0]        flags;
        logic [DATA_W-1:0] data;
    } sdl_block_s;

    typedef struct packed {
        logic [7:0] g4;
        logic [7:0] g3;
        logic [7:0] g2;
        logic [7:0] g1;
    } sdl_status_s;

    typedef struct packed {
        logic adc_done;
        logic print_tmo;
        logic timed_logging_tmo;
        logic meas_drop;
        logic unit_chg;
        logic cmd_err;
        logic exec_err;
    } sdl_events_s;

    typedef struct packed {
        logic chart_end;
        logic chart_feed;
        logic basic_set;
        logic recording;
        logic computing;
        logic alarm;
    } sdl_levels_s;

    function automatic logic [IDX_W-1:0] ring_inc(
        input logic [IDX_W-1:0] a,
        input logic [IDX_W-1:0] depth
    );
        ring_inc = (a == depth - 8'h01) ? 8'h00 : a + 8'h01;
    endfunction : ring_inc

    function automatic logic [IDX_W-1:0] ring_sub(
        input logic [IDX_W-1:0] a,
        input logic [IDX_W-1:0] b,
        input logic [IDX_W-1:0] depth
    );
        logic [IDX_W:0] t;
        t = (a >= b) ? {1'b0, a} - {1'b0, b}
                     : {1'b0, a} + {1'b0, depth} - {1'b0, b};
        ring_sub = t[IDX_W-1:0];
    endfunction : ring_sub

endpackage : sdl_pkg

// file: sdl_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock and synchronous active-low reset
`timescale 1ns/1ns
module sdl_fifo #(
    parameter int W     = 19,
    parameter int DEPTH = 4
) (
    input  wire logic         ref_clk,   // system clock
    input  wire logic         resetn,    // sync reset, active low
    input  wire logic         in_valid,  // write request
    output logic              in_ready,  // room available
    input  wire logic [W-1:0] in_data,   // write word
    output logic              out_valid, // word available
    input  wire logic         out_ready, // reader accepts
    output logic [W-1:0]      out_data   // head word
);
    localparam int PW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [PW:0]   count_reg;
    logic          push;
    logic          pop;

    assign in_ready  = (count_reg != (PW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0
                                                           : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0
                                                           : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule : sdl_fifo

// file: sdl_logger.sv
// status groups with per-connection filters, and the timed data ring
// assumes events are one-cycle pulses and levels are synchronous to ref_clk
`timescale 1ns/1ns
module sdl_logger
    import sdl_pkg::*;
#(
    parameter int MS_TICK = MS_CYCLES
) (
    input  wire logic              ref_clk,       // 125 MHz clock
    input  wire logic              resetn,        // sync reset, active low
    input  wire logic              dot_model,     // strap: 1 = dot ring size
    input  wire sdl_events_s       events,        // one-cycle event pulses
    input  wire sdl_levels_s       levels,        // live conditions
    input  wire logic              query_valid,   // status_query_cmd strobe
    input  wire logic [CONN_W-1:0] query_conn,    // connection asking
    output logic                   status_valid,  // answer strobe
    output sdl_status_s            status_out,    // four filtered groups
    input  wire logic              filt_we,       // filter write strobe
    input  wire logic [CONN_W-1:0] filt_conn,     // filter connection
    input  wire logic [1:0]        filt_group,    // group 0..3 = 1..4
    input  wire logic [7:0]        filt_data,     // filter value
    input  wire logic              ivl_we,        // acquire_interval_cmd
    input  wire logic [15:0]       ivl_ms,        // interval in ms
    input  wire logic [DATA_W-1:0] sample_data,   // current measured word
    input  wire logic              fifo_read_cmd, // start a ring read
    input  wire logic              read_newest,   // 1 newest_blocks_read
    input  wire logic [IDX_W-1:0]  read_count,    // blocks for newest read
    output logic                   read_busy,     // reader active
    output logic                   blk_valid,     // block available
    input  wire logic              blk_ready,     // host takes block
    output sdl_block_s             blk_data,      // block word
    input  wire sdl_unit_e         unit_sym,      // unit symbol
    output logic [7:0]             unit_code      // its character code
);

    // ---- status groups
    logic [7:0]  g1_hold_reg [NUM_CONN];
    logic [7:0]  g2_hold_reg [NUM_CONN];
    logic [7:0]  filt_reg    [NUM_CONN][4];
    logic [7:0]  ev_g1;
    logic [7:0]  ev_g2;
    logic [7:0]  live_g3;
    logic [7:0]  live_g4;

    always_comb begin
        ev_g1 = 8'h00;
        ev_g1[G1_ADC_DONE]  = events.adc_done;
        ev_g1[G1_PRINT_TMO] = events.print_tmo;
        ev_g1[G1_TIMED_LOGGING_TMO]  = events.timed_logging_tmo;
        ev_g2 = 8'h00;
        ev_g2[G2_MEAS_DROP] = events.meas_drop;
        ev_g2[G2_UNIT_CHG]  = events.unit_chg;
        ev_g2[G2_CMD_ERR]   = events.cmd_err;
        ev_g2[G2_EXEC_ERR]  = events.exec_err;
        live_g3 = 8'h00;
        live_g3[G3_CHART_END]  = levels.chart_end;
        live_g3[G3_CHART_FEED] = levels.chart_feed;
        live_g4 = 8'h00;
        live_g4[G4_BASIC] = levels.basic_set;
        live_g4[G4_REC]   = levels.recording;
        live_g4[G4_COMP]  = levels.computing;
        live_g4[G4_ALARM] = levels.alarm;
    end

    // held events per connection; a new event wins over the read clear
    always_ff @(posedge ref_clk) begin
        for (int c = 0; c < NUM_CONN; c++) begin
            if (!resetn) begin
                g1_hold_reg[c] <= 8'h00;
                g2_hold_reg[c] <= 8'h00;
            end else if (query_valid && query_conn == CONN_W'(c)) begin
                g1_hold_reg[c] <= ev_g1;
                g2_hold_reg[c] <= ev_g2;
            end else begin
                g1_hold_reg[c] <= g1_hold_reg[c] | ev_g1;
                g2_hold_reg[c] <= g2_hold_reg[c] | ev_g2;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        for (int c = 0; c < NUM_CONN; c++) begin
            for (int g = 0; g < 4; g++) begin
                if (!resetn) begin
                    filt_reg[c][g] <= FILTER_RST;
                end else if (filt_we && filt_conn == CONN_W'(c)
                             && filt_group == 2'(g)) begin
                    filt_reg[c][g] <= filt_data;
                end
            end
        end
    end

    // answer one cycle after the query, all four groups at once
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            status_valid <= 1'b0;
            status_out   <= '0;
        end else begin
            status_valid <= query_valid;
            if (query_valid) begin
                status_out.g1 <= g1_hold_reg[query_conn]
                                 & filt_reg[query_conn][0] & G1_USED;
                status_out.g2 <= g2_hold_reg[query_conn]
                                 & filt_reg[query_conn][1] & G2_USED;
                status_out.g3 <= live_g3
                                 & filt_reg[query_conn][2] & G3_USED;
                status_out.g4 <= live_g4
                                 & filt_reg[query_conn][3] & G4_USED;
            end
        end
    end

    // ---- ring depth, caught from the strap while reset is held
    logic [IDX_W-1:0] depth_reg;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            depth_reg <= dot_model ? DOT_DEPTH : PEN_DEPTH;
        end
    end

    // ---- acquire timing: ms enable, then interval count
    logic [16:0] ms_cnt_reg;
    logic        ms_tick;
    logic [15:0] ivl_reg;
    logic [15:0] ivl_cnt_reg;
    logic        acq_tick;

    assign ms_tick  = (ms_cnt_reg == 17'(MS_TICK - 1));
    assign acq_tick = ms_tick && (ivl_cnt_reg + 16'h0001 >= ivl_reg);

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ivl_reg <= IVL_RST_MS;
        end else if (ivl_we) begin
            ivl_reg <= ivl_ms;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn || ivl_we) begin
            ms_cnt_reg  <= '0;
            ivl_cnt_reg <= 16'h0000;
        end else begin
            ms_cnt_reg <= ms_tick ? '0 : ms_cnt_reg + 17'h0_0001;
            if (acq_tick) begin
                ivl_cnt_reg <= 16'h0000;
            end else if (ms_tick) begin
                ivl_cnt_reg <= ivl_cnt_reg + 16'h0001;
            end
        end
    end

    // ---- data ring
    sdl_block_s       ring_mem [MEM_WORDS];
    logic [IDX_W-1:0] wp_reg;
    logic [IDX_W-1:0] rp_reg;
    logic [IDX_W-1:0] fill_reg;
    logic [2:0]       pend_flags_reg;
    logic [2:0]       now_flags;

    always_comb begin
        now_flags = 3'h0;
        now_flags[FLG_DROP] = events.meas_drop;
        now_flags[FLG_IVL]  = ivl_we;
        now_flags[FLG_UNIT] = events.unit_chg;
    end

    always_ff @(posedge ref_clk) begin
        if (acq_tick) begin
            ring_mem[ring_inc(wp_reg, depth_reg)] <=
                '{flags: pend_flags_reg | now_flags, data: sample_data};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            pend_flags_reg <= 3'h0;
        end else if (acq_tick) begin
            pend_flags_reg <= 3'h0;
        end else begin
            pend_flags_reg <= pend_flags_reg | now_flags;
        end
    end

    // wp points at the newest block; it starts on the last slot
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            wp_reg   <= 8'hFF;
            fill_reg <= 8'h00;
        end else if (wp_reg >= depth_reg) begin
            wp_reg <= depth_reg - 8'h01;
        end else if (acq_tick) begin
            wp_reg <= ring_inc(wp_reg, depth_reg);
            if (fill_reg != depth_reg) begin
                fill_reg <= fill_reg + 8'h01;
            end
        end
    end

    // ---- reader
    sdl_rd_e          rd_state_reg;
    logic [IDX_W-1:0] rd_idx_reg;
    logic [IDX_W-1:0] rd_cnt_reg;
    sdl_block_s       rd_word_reg;
    logic [IDX_W-1:0] log_avail;
    logic [IDX_W-1:0] new_cnt;
    logic             push_valid;
    logic             push_ready;

    assign log_avail  = ring_sub(wp_reg, rp_reg, depth_reg);
    assign new_cnt    = (read_count > fill_reg) ? fill_reg : read_count;
    assign push_valid = (rd_state_reg == RD_PUSH);
    assign read_busy  = (rd_state_reg != RD_IDLE);

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rp_reg <= 8'hFF;
        end else if (rp_reg >= depth_reg) begin
            rp_reg <= depth_reg - 8'h01;
        end else if (rd_state_reg == RD_IDLE && fifo_read_cmd
                     && !read_newest) begin
            rp_reg <= wp_reg;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rd_state_reg <= RD_IDLE;
            rd_idx_reg   <= 8'h00;
            rd_cnt_reg   <= 8'h00;
        end else begin
            case (rd_state_reg)
                RD_IDLE: begin
                    if (fifo_read_cmd && !read_newest && log_avail != 0) begin
                        rd_idx_reg   <= ring_inc(rp_reg, depth_reg);
                        rd_cnt_reg   <= log_avail;
                        rd_state_reg <= RD_FETCH;
                    end else if (fifo_read_cmd && read_newest
                                 && new_cnt != 0) begin
                        rd_idx_reg <= ring_sub(wp_reg, new_cnt - 8'h01,
                                               depth_reg);
                        rd_cnt_reg   <= new_cnt;
                        rd_state_reg <= RD_FETCH;
                    end
                end
                RD_FETCH: begin
                    rd_state_reg <= RD_PUSH;
                end
                RD_PUSH: begin
                    if (push_ready) begin
                        rd_idx_reg   <= ring_inc(rd_idx_reg, depth_reg);
                        rd_cnt_reg   <= rd_cnt_reg - 8'h01;
                        rd_state_reg <= (rd_cnt_reg == 8'h01) ? RD_IDLE
                                                              : RD_FETCH;
                    end
                end
                default: begin
                    rd_state_reg <= RD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rd_state_reg == RD_FETCH) begin
            rd_word_reg <= ring_mem[rd_idx_reg];
        end
    end

    sdl_fifo #(
        .W     ($bits(sdl_block_s)),
        .DEPTH (OUT_FIFO_DEPTH)
    ) u_out_fifo (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (rd_word_reg),
        .out_valid (blk_valid),
        .out_ready (blk_ready),
        .out_data  (blk_data)
    );

    // ---- unit character codes
    function automatic logic [7:0] unit_to_code(input sdl_unit_e s);
        case (s)
            UNIT_MICRO:  unit_to_code = CODE_MICRO;
            UNIT_OHM:    unit_to_code = CODE_OHM;
            UNIT_SQUARE: unit_to_code = CODE_SQUARE;
            UNIT_CUBE:   unit_to_code = CODE_CUBE;
            UNIT_DEGREE: unit_to_code = CODE_DEGREE;
            default:     unit_to_code = 8'h00;
        endcase
    endfunction : unit_to_code

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            unit_code <= 8'h00;
        end else begin
            unit_code <= unit_to_code(unit_sym);
        end
    end

    // ---- checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence query_c0;
        query_valid && query_conn == 1'b0;
    endsequence

    sequence answer_g1_clear;
        status_valid ##0 g1_hold_reg[0] == 8'h00;
    endsequence

    adc_event_held_a: assert property (events.adc_done && !query_valid
        |=> g1_hold_reg[0][G1_ADC_DONE] && g1_hold_reg[1][G1_ADC_DONE])
        else $error("adc event not held");
    print_event_held_a: assert property (events.print_tmo
        |=> g1_hold_reg[0][G1_PRINT_TMO])
        else $error("print timeout not held");
    timed_logging_event_held_a: assert property (events.timed_logging_tmo
        |=> g1_hold_reg[1][G1_TIMED_LOGGING_TMO])
        else $error("timed logging expiry not held");
    error_events_held_a: assert property (
        (events.meas_drop && events.unit_chg && events.cmd_err
         && events.exec_err) |=> g2_hold_reg[0][3:0] == 4'hF)
        else $error("group 2 events not held");
    read_clears_a: assert property (query_c0 ##0 ev_g1 == 8'h00
        |=> answer_g1_clear)
        else $error("group 1 not cleared by read");
    live_group_a: assert property (query_c0 |=> status_valid
        && status_out.g4 == ($past(live_g4) & $past(filt_reg[0][3])))
        else $error("group 4 not live and filtered");
    unused_zero_a: assert property (status_valid |->
        (status_out.g1 & ~G1_USED) == 8'h00
        && (status_out.g3 & ~G3_USED) == 8'h00)
        else $error("unused status bit set");
    ring_wrap_a: assert property (acq_tick && wp_reg == depth_reg - 8'h01
        |=> wp_reg == 8'h00)
        else $error("ring did not wrap");
    log_read_rp_a: assert property (rd_state_reg == RD_IDLE
        && fifo_read_cmd && !read_newest |=> rp_reg == $past(wp_reg))
        else $error("prior position not moved");
    newest_count_a: assert property (rd_state_reg == RD_IDLE
        && fifo_read_cmd && read_newest && new_cnt != 0
        |=> rd_cnt_reg == $past(new_cnt) ##1 rd_state_reg == RD_PUSH)
        else $error("newest read count wrong");
    ohm_code_a: assert property (unit_sym == UNIT_OHM
        |=> unit_code == CODE_OHM)
        else $error("ohm code wrong");

endmodule : sdl_logger

// file: sdl_host_model.sv
// host side sink that takes ring blocks, promptly or slowly
// assumes blk_* come from sdl_logger on the same ref_clk
`timescale 1ns/1ns
module sdl_host_model
    import sdl_pkg::*;
(
    input  wire logic       ref_clk,   // system clock
    input  wire logic       resetn,    // sync reset, active low
    input  wire logic       slow,      // take one block in four cycles
    input  wire logic       blk_valid, // block offered
    output logic            blk_ready, // block accepted
    input  wire sdl_block_s blk_data   // block word
);
    sdl_block_s got [0:63];
    int         n;
    logic [1:0] cyc_reg;

    // stalling keeps the small output fifo full and the reader waiting
    always_ff @(posedge ref_clk) begin
        cyc_reg   <= resetn ? cyc_reg + 2'h1 : 2'h0;
        blk_ready <= resetn && (!slow || cyc_reg == 2'h0);
        if (blk_valid && blk_ready) begin
            got[n % 64] <= blk_data;
            n           <= n + 1;
        end
    end
endmodule : sdl_host_model

// file: sdl_logger_bench.sv
// self-checking bench for sdl_logger with a host sink model
// assumes MS_TICK of 4 cycles so one block lands every 4 cycles
`timescale 1ns/1ns
module sdl_logger_bench;
    import sdl_pkg::*;
    logic              ref_clk = 0, resetn = 0, dot_model = 1, slow = 0;
    logic              query_valid = 0, filt_we = 0, ivl_we = 0;
    logic              fifo_read_cmd = 0, read_newest = 0, blk_ready;
    logic [CONN_W-1:0] query_conn = 0, filt_conn = 0;
    logic [1:0]        filt_group = 0;
    logic [7:0]        filt_data = 0, read_count = 0, unit_code;
    logic [15:0]       ivl_ms = 0;
    logic [DATA_W-1:0] sample_data = 0;
    sdl_events_s       events = '0;
    sdl_levels_s       levels = '0;
    sdl_unit_e         unit_sym = UNIT_MICRO;
    logic              status_valid, read_busy, blk_valid;
    sdl_status_s       status_out;
    sdl_block_s        blk_data;
    int                fail_count = 0, check_count = 0, base, got_n;
    logic [7:0]        ucode [0:5] = '{8'h7B, 8'h7C, 8'h7D, 8'h7E, 8'h5E,
                                       8'h00};

    sdl_logger #(.MS_TICK(4)) i_dut (.ref_clk, .resetn, .dot_model,
        .events, .levels, .query_valid, .query_conn, .status_valid,
        .status_out, .filt_we, .filt_conn, .filt_group, .filt_data, .ivl_we,
        .ivl_ms, .sample_data, .fifo_read_cmd, .read_newest, .read_count,
        .read_busy, .blk_valid, .blk_ready, .blk_data, .unit_sym, .unit_code);
    sdl_host_model i_host (.ref_clk, .resetn, .slow, .blk_valid, .blk_ready,
        .blk_data);

    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) sample_data <= sample_data + 16'h0001;

    task test_done;
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task qry(input logic c, input logic [31:0] exp);
        @(posedge ref_clk);
        query_valid <= 1;
        query_conn  <= c;
        @(posedge ref_clk);
        query_valid <= 0;
        @(negedge ref_clk);
        check(status_valid, 1'b1);
        check(status_out, exp);
        @(posedge ref_clk);
    endtask : qry

    // one ring read; got_n is the number of blocks the host took
    task rd(input logic nw, input logic [7:0] cnt);
        int t;
        base = i_host.n;
        @(posedge ref_clk);
        fifo_read_cmd <= 1;
        read_newest   <= nw;
        read_count    <= cnt;
        @(posedge ref_clk);
        fifo_read_cmd <= 0;
        repeat (4) @(posedge ref_clk);
        for (t = 0; t < 3000 && (read_busy || blk_valid); t++)
            @(posedge ref_clk);
        repeat (2) @(posedge ref_clk);
        got_n = i_host.n - base;
    endtask : rd

    function automatic logic [15:0] dat(input int k);
        return i_host.got[(base + k) % 64].data;
    endfunction : dat

    initial begin
        #(8 * 30000);
        fail_count++;
        test_done;
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        resetn <= 1;
        for (int i = 0; i < 6; i++) begin
            @(posedge ref_clk);
            unit_sym <= sdl_unit_e'(i);
            repeat (2) @(posedge ref_clk);
            check(unit_code, ucode[i]);
        end
        @(posedge ref_clk);
        events <= '1;
        @(posedge ref_clk);
        events <= '0;
        qry(0, 32'h0000_0F0D);
        qry(0, 32'h0000_0000);
        @(posedge ref_clk);
        levels <= '1;
        qry(0, 32'h0F22_0000);
        qry(0, 32'h0F22_0000);
        @(posedge ref_clk);
        filt_we    <= 1;
        filt_conn  <= 1;
        filt_data  <= 8'h01;
        @(posedge ref_clk);
        filt_we <= 0;
        qry(1, 32'h0F22_0F01);
        levels <= '0;
        qry(1, 32'h0000_0000);
        // two blocks, park, then a logging read takes exactly those two
        ivl_we <= 1;
        ivl_ms <= 16'h0001;
        @(posedge ref_clk);
        ivl_we <= 0;
        repeat (10) @(posedge ref_clk);
        ivl_we <= 1;
        ivl_ms <= 16'hFFFF;
        @(posedge ref_clk);
        ivl_we <= 0;
        repeat (10) @(posedge ref_clk);
        rd(0, 8'h00);
        check(got_n, 2);
        check(dat(1) - dat(0), 16'h0004);
        // interval first, then let the ring wrap, then park acquisition
        ivl_we <= 1;
        ivl_ms <= 16'h0001;
        @(posedge ref_clk);
        ivl_we <= 0;
        repeat (300) @(posedge ref_clk);
        ivl_we <= 1;
        ivl_ms <= 16'hFFFF;
        @(posedge ref_clk);
        ivl_we <= 0;
        repeat (10) @(posedge ref_clk);
        rd(1, 8'h05);
        check(got_n, 5);
        for (int k = 0; k < 4; k++)
            check(dat(k + 1) - dat(k), 16'h0004);
        rd(0, 8'h00);
        rd(0, 8'h00);
        check(got_n, 0);
        slow <= 1;
        rd(1, 8'hFF);
        check(got_n, 60);
        check(dat(59) - dat(0), 16'h00EC);
        // second reset with the pen strap: ring holds 240 blocks
        resetn    <= 0;
        dot_model <= 0;
        slow      <= 0;
        repeat (20) @(posedge ref_clk);
        resetn <= 1;
        @(posedge ref_clk);
        ivl_we <= 1;
        ivl_ms <= 16'h0001;
        @(posedge ref_clk);
        ivl_we <= 0;
        repeat (1000) @(posedge ref_clk);
        ivl_we <= 1;
        ivl_ms <= 16'hFFFF;
        @(posedge ref_clk);
        ivl_we <= 0;
        repeat (10) @(posedge ref_clk);
        rd(1, 8'hFF);
        check(got_n, 240);
        check(dat(239) - dat(238), 16'h0004);
        test_done;
    end
endmodule : sdl_logger_bench
